/* File: cstl_pkg.sv */
// Purpose: constants and carriers for the quadrant memory tuning and layer limit registers
// Assumes: 32-bit register port, word offsets as byte addresses
// Notes: shared by the design and the bench
`default_nettype none
package cstl_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] MEM_TUNING_OFS = 8'h04;
	localparam logic [7:0] LAST_LAYER_OFS = 8'h08;
	localparam logic [7:0] RUN_CTRL_OFS = 8'h0c;
	localparam int READ_ASSIST_LSB = 6;
	localparam int MARGIN_LSB = 2;
	localparam int MARGIN_OVERRIDE_BIT = 1;
	localparam int EXT_ACCESS_BIT = 0;
	localparam int SLEEP_BIT = 15;
	localparam int MARGIN_SELECT_BIT = 1;
	localparam int RUN_ENABLE_BIT = 0;
	localparam logic [1:0] READ_ASSIST_RST = 2'h0;
	localparam logic [3:0] MARGIN_RST = 4'h3;
	localparam logic [3:0] MARGIN_FASTEST = 4'h3;
	localparam logic MARGIN_OVERRIDE_RST = 1'b1;
	localparam logic EXT_ACCESS_RST = 1'b0;
	localparam logic SLEEP_RST = 1'b0;
	localparam logic [4:0] LAST_LAYER_RST = 5'h00;

	typedef struct packed {
		logic sleep;
		logic [1:0] readAssist;
		logic [3:0] margin;
		logic marginOverride;
		logic extAccess;
	} cstl_mem_cfg_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} cstl_bus_req_t;
endpackage
`default_nettype wire

/* File: cstl_regs.sv */
// Purpose: memory tuning control and last layer limit registers of one quadrant
// Assumes: single clock, synchronous reset, read data one cycle after read strobe
// Notes: run control register at 0x0c holds run enable and margin select
// Contract
// - Two-bit read assist at 7:6, reset 0
// - Four-bit margin at 5:2, reset 0011
// - Margin ignored unless margin select is on
// - Override bit 1 resets 1, chooses register timing
// - Extended access bit 0 forces maximum time; here only stored and passed out on memCfg
// - Five-bit last layer index at 4:0
// - Sleep bit 15 retains, blocks, zeroes outputs; here only stored and passed out on memCfg
//
// Our own choice: the address-and-strobe port.
`default_nettype none
module cstl_regs (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Register port
	input wire cstl_pkg::cstl_bus_req_t busReq,
	output logic [31:0] rdData,
	// Memory macros
	output cstl_pkg::cstl_mem_cfg_t memCfg,
	output logic useRegTiming,
	output logic [3:0] effMargin,
	// Layer sequencer
	output logic runEnable,
	output logic [4:0] lastLayer,
	output logic lastLayerWriteIgnored
);

	////////////////////////////////////////////////////////////////////
	// Decode
	// One compare shared by write decode and read mux
	function automatic logic addrHit(
		input logic [cstl_pkg::ADDR_W-1:0] addr,
		input logic [cstl_pkg::ADDR_W-1:0] ofs
	);
		return addr == ofs;
	endfunction

	wire hitTuning = addrHit(busReq.addr, cstl_pkg::MEM_TUNING_OFS);
	wire hitLayer = addrHit(busReq.addr, cstl_pkg::LAST_LAYER_OFS);
	wire hitRun = addrHit(busReq.addr, cstl_pkg::RUN_CTRL_OFS);

	// Write enables
	wire wrTuning = busReq.wr && hitTuning;
	wire wrLayer = busReq.wr && hitLayer;
	wire wrRun = busReq.wr && hitRun;

	////////////////////////////////////////////////////////////////////
	// Elaboration checks
	// Offsets up to 0x0c need four address bits
	if (cstl_pkg::ADDR_W < 4) begin : g_addrTooNarrow
		$error("register port address too narrow for the offset map");
	end
	// Every field must sit inside the 32-bit data word
	if (cstl_pkg::SLEEP_BIT > 31) begin : g_sleepOutside
		$error("sleep bit outside the data word");
	end
	if (cstl_pkg::READ_ASSIST_LSB + 2 > 32) begin : g_assistOutside
		$error("read assist field outside the data word");
	end
	if (cstl_pkg::MARGIN_LSB + 4 > 32) begin : g_marginOutside
		$error("margin field outside the data word");
	end
	// Reset margin must not land on a reserved code
	if (cstl_pkg::MARGIN_RST > cstl_pkg::MARGIN_FASTEST) begin : g_marginRstReserved
		$error("margin reset value is a reserved code");
	end
	// Fastest code is the fallback timing, so it must be legal too
	if (cstl_pkg::MARGIN_FASTEST > 4'h3) begin : g_fastestReserved
		$error("fallback margin is a reserved code");
	end
	// Run control bits, or the override and extended access bits, would alias each other
	if (cstl_pkg::RUN_ENABLE_BIT == cstl_pkg::MARGIN_SELECT_BIT) begin : g_runBitsClash
		$error("run enable and margin select share a bit");
	end
	if (cstl_pkg::MARGIN_OVERRIDE_BIT == cstl_pkg::EXT_ACCESS_BIT) begin : g_tuneBitsClash
		$error("override and extended access share a bit");
	end

	////////////////////////////////////////////////////////////////////
	// State
	logic [1:0] readAssist_reg;
	logic [1:0] readAssist_next;
	logic [3:0] margin_reg;
	logic [3:0] margin_next;
	logic override_reg;
	logic override_next;
	logic extAccess_reg;
	logic extAccess_next;
	logic sleep_reg;
	logic sleep_next;
	logic [4:0] lastLayer_reg;
	logic [4:0] lastLayer_next;
	logic runEnable_reg;
	logic runEnable_next;
	logic marginSelect_reg;
	logic marginSelect_next;
	logic ignored_reg;
	logic ignored_next;
	logic [31:0] rdData_reg;
	logic [31:0] rdData_next;

	////////////////////////////////////////////////////////////////////
	// Write data fields
	wire [1:0] wdAssist = busReq.wdata[cstl_pkg::READ_ASSIST_LSB +: 2];
	wire [3:0] wdMargin = busReq.wdata[cstl_pkg::MARGIN_LSB +: 4];
	wire wdOverride = busReq.wdata[cstl_pkg::MARGIN_OVERRIDE_BIT];
	wire wdExtAccess = busReq.wdata[cstl_pkg::EXT_ACCESS_BIT];
	wire wdSleep = busReq.wdata[cstl_pkg::SLEEP_BIT];
	wire [4:0] wdLayer = busReq.wdata[4:0];
	wire wdRunEnable = busReq.wdata[cstl_pkg::RUN_ENABLE_BIT];
	wire wdMarginSelect = busReq.wdata[cstl_pkg::MARGIN_SELECT_BIT];

	// Index frozen while running, so the sequencer never sees a moving limit
	wire layerWriteOk = wrLayer && !runEnable_reg;
	wire layerWriteBusy = wrLayer && runEnable_reg;

	////////////////////////////////////////////////////////////////////
	// Next values
	assign readAssist_next = wrTuning ? wdAssist : readAssist_reg;
	assign margin_next = wrTuning ? wdMargin : margin_reg;
	assign override_next = wrTuning ? wdOverride : override_reg;
	assign extAccess_next = wrTuning ? wdExtAccess : extAccess_reg;
	assign sleep_next = wrTuning ? wdSleep : sleep_reg;
	assign lastLayer_next = layerWriteOk ? wdLayer : lastLayer_reg;
	assign runEnable_next = wrRun ? wdRunEnable : runEnable_reg;
	assign marginSelect_next = wrRun ? wdMarginSelect : marginSelect_reg;
	// Sticky until the next layer write that lands
	assign ignored_next = layerWriteBusy ? 1'b1 : layerWriteOk ? 1'b0 : ignored_reg;

	////////////////////////////////////////////////////////////////////
	// Memory tuning registers
	// Read assist level
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			readAssist_reg <= cstl_pkg::READ_ASSIST_RST;
		end else begin
			readAssist_reg <= readAssist_next;
		end
	end

	// Margin code, reserved codes stored as written
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			margin_reg <= cstl_pkg::MARGIN_RST;
		end else begin
			margin_reg <= margin_next;
		end
	end

	// Register timing override
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			override_reg <= cstl_pkg::MARGIN_OVERRIDE_RST;
		end else begin
			override_reg <= override_next;
		end
	end

	// Extended access
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			extAccess_reg <= cstl_pkg::EXT_ACCESS_RST;
		end else begin
			extAccess_reg <= extAccess_next;
		end
	end

	// Deep sleep
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sleep_reg <= cstl_pkg::SLEEP_RST;
		end else begin
			sleep_reg <= sleep_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Layer limit registers
	// Last layer index
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			lastLayer_reg <= cstl_pkg::LAST_LAYER_RST;
		end else begin
			lastLayer_reg <= lastLayer_next;
		end
	end

	// Refused write flag
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ignored_reg <= 1'b0;
		end else begin
			ignored_reg <= ignored_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Run control registers
	// Run enable
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			runEnable_reg <= 1'b0;
		end else begin
			runEnable_reg <= runEnable_next;
		end
	end

	// Margin select
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			marginSelect_reg <= 1'b0;
		end else begin
			marginSelect_reg <= marginSelect_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdData_reg <= 32'h00000000;
		end else begin
			rdData_reg <= rdData_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read back
	function automatic logic [31:0] packTuning(input cstl_pkg::cstl_mem_cfg_t cfg);
		logic [31:0] word;
		word = 32'h00000000;
		word[cstl_pkg::SLEEP_BIT] = cfg.sleep;
		word[cstl_pkg::READ_ASSIST_LSB +: 2] = cfg.readAssist;
		word[cstl_pkg::MARGIN_LSB +: 4] = cfg.margin;
		word[cstl_pkg::MARGIN_OVERRIDE_BIT] = cfg.marginOverride;
		word[cstl_pkg::EXT_ACCESS_BIT] = cfg.extAccess;
		return word;
	endfunction

	function automatic logic [31:0] packLayer(input logic [4:0] layer);
		logic [31:0] word;
		word = 32'h00000000;
		word[4:0] = layer;
		return word;
	endfunction

	function automatic logic [31:0] packRun(input logic runOn, input logic selectOn);
		logic [31:0] word;
		word = 32'h00000000;
		word[cstl_pkg::RUN_ENABLE_BIT] = runOn;
		word[cstl_pkg::MARGIN_SELECT_BIT] = selectOn;
		return word;
	endfunction

	wire cstl_pkg::cstl_mem_cfg_t storedCfg;
	assign storedCfg.sleep = sleep_reg;
	assign storedCfg.readAssist = readAssist_reg;
	assign storedCfg.margin = margin_reg;
	assign storedCfg.marginOverride = override_reg;
	assign storedCfg.extAccess = extAccess_reg;

	localparam int NUM_WORDS = 3;
	wire [cstl_pkg::ADDR_W-1:0] wordOfs [NUM_WORDS];
	wire [31:0] wordVal [NUM_WORDS];
	wire [31:0] wordSel [NUM_WORDS];
	wire [31:0] rdMux;

	assign wordOfs[0] = cstl_pkg::MEM_TUNING_OFS;
	assign wordOfs[1] = cstl_pkg::LAST_LAYER_OFS;
	assign wordOfs[2] = cstl_pkg::RUN_CTRL_OFS;
	assign wordVal[0] = packTuning(storedCfg);
	assign wordVal[1] = packLayer(lastLayer_reg);
	assign wordVal[2] = packRun(runEnable_reg, marginSelect_reg);

	// Unmapped offsets miss every slot and read zero
	for (genvar gi = 0; gi < NUM_WORDS; gi++) begin : g_rdSlot
		assign wordSel[gi] = addrHit(busReq.addr, wordOfs[gi]) ? wordVal[gi] : 32'h00000000;
	end
	assign rdMux = wordSel[0] | wordSel[1] | wordSel[2];
	// Data only in the cycle after a read strobe, zero otherwise
	assign rdData_next = busReq.rd ? rdMux : 32'h00000000;

	////////////////////////////////////////////////////////////////////
	// Outputs
	// Margin reaches the macros only when selected and override is set; else fastest code
	wire marginActive = marginSelect_reg && override_reg;
	assign effMargin = marginActive ? margin_reg : cstl_pkg::MARGIN_FASTEST;
	assign useRegTiming = override_reg;
	// Sleep is stored here; blocking and zeroing belong to the macros
	assign memCfg = storedCfg;
	assign runEnable = runEnable_reg;
	assign lastLayer = lastLayer_reg;
	assign lastLayerWriteIgnored = ignored_reg;
	assign rdData = rdData_reg;

endmodule
`default_nettype wire

/* File: cstl_regs_asserts.sv */
// Purpose: port checks of cstl_regs
// Assumes: one clock, sync reset
// Notes: fields seen one cycle after a write
`default_nettype none
module cstl_regs_asserts (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Watched ports
	input wire cstl_pkg::cstl_bus_req_t busReq,
	input wire logic [31:0] rdData,
	input wire cstl_pkg::cstl_mem_cfg_t memCfg,
	input wire logic useRegTiming,
	input wire logic [3:0] effMargin,
	input wire logic runEnable,
	input wire logic [4:0] lastLayer,
	input wire logic lastLayerWriteIgnored
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	wire logic wT = busReq.wr && busReq.addr == 8'h04;
	wire logic wL = busReq.wr && busReq.addr == 8'h08;
	wire logic [31:0] d = busReq.wdata;
	AST_ASSIST: assert property (wT |=> memCfg.readAssist == $past(d[7:6]))
		else $error("assist level not stored");
	AST_MARGIN: assert property (wT |=> memCfg.margin == $past(d[5:2]))
		else $error("margin not stored");
	AST_GATE: assert property (!useRegTiming |-> effMargin == 4'h3)
		else $error("margin applied without override");
	AST_OVR: assert property (wT |=> useRegTiming == $past(d[1]))
		else $error("override not stored");
	AST_EXT: assert property (wT |=> memCfg.extAccess == $past(d[0]))
		else $error("extended access not stored");
	AST_LL: assert property (wL && !runEnable |=> lastLayer == $past(d[4:0]))
		else $error("layer index not stored");
	AST_BUSY: assert property (wL && runEnable |=> $stable(lastLayer))
		else $error("layer index moved while running");
	AST_BUSY_FLAG: assert property (wL && runEnable |=> lastLayerWriteIgnored)
		else $error("refused layer write not flagged");
	AST_SLEEP: assert property (wT |=> memCfg.sleep == $past(d[15]))
		else $error("sleep bit not stored");
	AST_RSV: assert property (busReq.rd && busReq.addr == 8'h08 |=> rdData[31:5] == 27'h0)
		else $error("reserved layer bits not zero");
	// Main scenarios reached
	cover property (wL && runEnable);
	cover property (wT && d[1]);
	cover property (busReq.rd);
endmodule
bind cstl_regs cstl_regs_asserts u_chk (.sys_clk, .srst, .busReq, .rdData, .memCfg,
	.useRegTiming, .effMargin, .runEnable, .lastLayer, .lastLayerWriteIgnored);
`default_nettype wire

/* File: testbench.sv */
// Purpose: random register traffic against a model
// Assumes: reads answer one cycle later
// Notes: one idle cycle between requests
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0;
	logic srst = 1;
	cstl_pkg::cstl_bus_req_t busReq = '0;
	logic [31:0] rdData;
	cstl_pkg::cstl_mem_cfg_t memCfg;
	logic useRegTiming, runEnable, ign, ig = 0;
	logic [3:0] effMargin;
	logic [4:0] lastLayer;
	logic [7:0] lf = 8'h5c;
	logic [31:0] tw = 32'he, ll = 0, rc = 0;
	int bad_count = 0, num_checks = 0, cyc = 0;
	cstl_regs u_cstl_regs (.sys_clk, .srst, .busReq, .rdData, .memCfg, .useRegTiming,
		.effMargin, .runEnable, .lastLayer, .lastLayerWriteIgnored(ign));
	////////////////////////////////
	initial forever #5 sys_clk = ~sys_clk;
	function automatic logic [7:0] nx(logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(logic [31:0] g, logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic close_out;
		if (bad_count == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Model updated before compare, as outputs land on the strobe edge
	task automatic op(logic w, logic [7:0] a, logic [31:0] d);
		logic [31:0] e;
		@(posedge sys_clk);
		busReq <= '{a, d, w, !w};
		@(posedge sys_clk);
		busReq.wr <= 1'b0;
		busReq.rd <= 1'b0;
		e = 0;
		if (w && a == 8'h04) tw = d & 32'h80ff;
		if (w && a == 8'h08) ig = rc[0];
		if (w && a == 8'h08 && !rc[0]) ll = d & 32'h1f;
		if (w && a == 8'h0c) rc = d & 32'h3;
		if (!w) e = a == 8'h04 ? tw : a == 8'h08 ? ll : a == 8'h0c ? rc : 0;
		#1;
		chk(rdData, e);
		chk(effMargin, rc[1] && tw[1] ? tw[5:2] : 4'h3);
		chk(lastLayer, ll);
		chk(ign, ig);
		chk(runEnable, rc[0]);
		chk({useRegTiming, memCfg}, {tw[1], tw[15], tw[7:0]});
	endtask
	////////////////////////////////
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			close_out();
		end
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		op(0, 8'h04, 0);
		op(0, 8'h08, 0);
		repeat (300) begin
			lf = nx(lf);
			op(lf[0], {3'h0, 3'(lf[2:1]) + 3'd1, 2'h0}, {lf, nx(lf), lf, ~lf});
		end
		// Second reset mid run must bring back the reset words
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		tw = 32'he;
		ll = 0;
		rc = 0;
		ig = 0;
		op(0, 8'h04, 0);
		op(0, 8'h0c, 0);
		op(0, 8'h08, 0);
		close_out();
	end
endmodule
`default_nettype wire
